// [common/wdc_pkg.sv]
// Constants, register map and helper functions for the watchdog configuration decoder.
// Assumes one 100 MHz clock and a configuration word that is stable while the part runs.
package wdc_pkg;

  // ----------------------------------------------------------------
  // Configuration word layout
  // ----------------------------------------------------------------
  localparam int WDC_CFG_W = 32;
  localparam int WDC_WSZ_LSB = 24;
  localparam int WDC_FORCE_BIT = 23;
  localparam int WDC_WDIS_BIT = 22;
  localparam int WDC_PS_LSB = 16;
  localparam int WDC_PS_W = 5;
  localparam logic [4:0] WDC_PS_MAX = 5'h14;
  localparam int WDC_CNT_W = 21;

  // Window start as eighths of the period, per window size code.
  localparam logic [2:0] WDC_K_W25 = 3'h6;
  localparam logic [2:0] WDC_K_W37 = 3'h5;
  localparam logic [2:0] WDC_K_W50 = 3'h4;
  localparam logic [2:0] WDC_K_W75 = 3'h2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int WDC_CLK_PERIOD_NS = 10;
  localparam int WDC_TB_PERIOD_NS = 1000;
  localparam int WDC_TB_CYCLES = (WDC_TB_PERIOD_NS + WDC_CLK_PERIOD_NS - 1) / WDC_CLK_PERIOD_NS;
  localparam int WDC_SYNC_CYCLES = 2;

  // ----------------------------------------------------------------
  // Register map and reset values
  // ----------------------------------------------------------------
  localparam int WDC_AW = 8;
  localparam logic [7:0] WDC_A_CTRL = 8'h00;
  localparam logic [7:0] WDC_A_KICK = 8'h04;
  localparam logic [7:0] WDC_A_STAT = 8'h08;
  localparam logic [7:0] WDC_A_CFG = 8'h0c;
  localparam logic [7:0] WDC_A_CNT = 8'h10;
  localparam logic [7:0] WDC_A_IST = 8'h14;
  localparam logic [7:0] WDC_A_IEN = 8'h18;
  localparam logic [7:0] WDC_A_ICLR = 8'h1c;
  localparam int WDC_IRQ_N = 2;
  localparam int WDC_IRQ_TMO = 0;
  localparam int WDC_IRQ_EARLY = 1;
  localparam logic WDC_SWEN_RST = 1'b0;
  localparam logic [1:0] WDC_IEN_RST = 2'h0;
  localparam logic [31:0] WDC_CFG_RST = 32'hffff_ffff;

  typedef enum logic [1:0] {WDC_LOAD, WDC_IDLE, WDC_RUN} wdc_state_type;

  // Codes above the top encoding act as the top encoding.
  function automatic logic [4:0] wdc_ps_sat(input logic [4:0] ps);
    return (ps > WDC_PS_MAX) ? WDC_PS_MAX : ps;
  endfunction : wdc_ps_sat

  // Count value at which the clearing window opens.
  function automatic logic [20:0] wdc_open_at(input logic [4:0] ps, input logic [1:0] wsz);
    logic [2:0] k;
    logic [26:0] prod;
    case (wsz)
      2'h3: k = WDC_K_W25;
      2'h2: k = WDC_K_W37;
      2'h1: k = WDC_K_W50;
      default: k = WDC_K_W75;
    endcase
    prod = (27'h1 << ps) * {24'h0, k};
    return prod[23:3];
  endfunction : wdc_open_at

endpackage : wdc_pkg

// [common/wdc_ps_if.sv]
// Link between the watchdog control logic and its postscale counter.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface wdc_ps_if;
  logic tick;
  logic restart;
  logic [4:0] ps_sel;
  logic [20:0] count;
  logic expired;
  modport ctl (output tick, output restart, output ps_sel, input count, input expired);
  modport cnt (input tick, input restart, input ps_sel, output count, output expired);
endinterface : wdc_ps_if

// [core/wdc_postscaler.sv]
// Postscale counter: counts time base ticks and flags the end of each period.
// Assumes restart is raised whenever the watchdog is stopped or cleared.
`timescale 1ns/1ps
module wdc_postscaler
  import wdc_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  wdc_ps_if.cnt ps
);

  logic [20:0] count_ff;
  logic [20:0] nxt_count;
  wire logic [20:0] last_cnt;
  wire logic at_end;

  // ----------------------------------------------------------------
  // Period end decode
  // ----------------------------------------------------------------
  // A period is two to the selected code ticks long.
  assign last_cnt = WDC_CNT_W'((22'h1 << ps.ps_sel) - 22'h1);
  assign at_end = (count_ff >= last_cnt);
  assign ps.expired = ps.tick && !ps.restart && at_end;
  assign ps.count = count_ff;
  assign nxt_count = ps.restart ? '0 : (ps.tick ? (at_end ? '0 : count_ff + 21'h1) : count_ff);

  // Counter register.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_ff <= '0;
    end else begin
      count_ff <= nxt_count;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_period_end: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ps.expired |-> ##1 (count_ff == 21'h0)) else $error("Counter did not wrap after period end.");
  a_period_four: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (ps.ps_sel == 5'h2 && ps.tick && !ps.restart && count_ff == 21'h3) |-> ps.expired)
    else $error("Ratio 1:4 period did not end at count three.");

endmodule : wdc_postscaler

// [core/wdc_top.sv]
// Watchdog built from the device configuration word, with a small register port.
// Assumes the configuration word is static and comes from outside the clock domain.
`timescale 1ns/1ps
module wdc_top
  import wdc_pkg::*;
#(
  parameter int TB_CYCLES = WDC_TB_CYCLES
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [31:0] cfg_word_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic irq_o,
  output logic timeout_o,
  output logic running_o
);

  wdc_ps_if ps_link ();

  logic [31:0] cfg_s1_ff;
  logic [31:0] cfg_s2_ff;
  logic [31:0] cfg_ff;
  logic [1:0] ld_cnt_ff;
  wdc_state_type state_ff;
  wdc_state_type nxt_state;
  logic sw_en_ff;
  logic [15:0] tb_cnt_ff;
  logic [1:0] ist_ff;
  logic [1:0] ien_ff;
  logic [31:0] nxt_rdata;

  // ----------------------------------------------------------------
  // Configuration field decode
  // ----------------------------------------------------------------
  // Reserved bits are carried but never interpreted; their values are the programmer's concern.
  wire logic [1:0] wsz = cfg_ff[WDC_WSZ_LSB +: 2];
  wire logic forced = cfg_ff[WDC_FORCE_BIT];
  wire logic wdis = cfg_ff[WDC_WDIS_BIT];
  wire logic [4:0] ps_raw = cfg_ff[WDC_PS_LSB +: WDC_PS_W];
  wire logic [4:0] ps_eff = wdc_ps_sat(ps_raw);
  wire logic [20:0] open_at = wdc_open_at(ps_eff, wsz);
  wire logic ld_done = (ld_cnt_ff == 2'(WDC_SYNC_CYCLES));

  // ----------------------------------------------------------------
  // Register port decode
  // ----------------------------------------------------------------
  wire logic running = (state_ff == WDC_RUN);
  wire logic wr_ctrl = wr_i && (addr_i == WDC_A_CTRL);
  wire logic kick = wr_i && (addr_i == WDC_A_KICK) && wdata_i[0] && running;
  wire logic wr_ien = wr_i && (addr_i == WDC_A_IEN);
  wire logic [1:0] iclr = (wr_i && (addr_i == WDC_A_ICLR)) ? wdata_i[1:0] : 2'h0;

  // ----------------------------------------------------------------
  // Window and fault decode
  // ----------------------------------------------------------------
  // The window is always open in non-window operation.
  wire logic win_reached = (ps_link.count >= open_at);
  wire logic win_open = wdis || win_reached;
  wire logic early = kick && !win_open;
  wire logic tmo_ev = ps_link.expired || early;
  wire logic [1:0] ev_set = {early, ps_link.expired};
  wire logic [1:0] nxt_ist = (ist_ff & ~iclr) | ev_set;

  // Postscaler hookup: a clear, early or not, restarts the count.
  assign ps_link.tick = running && (tb_cnt_ff == 16'(TB_CYCLES - 1));
  assign ps_link.restart = !running || kick;
  assign ps_link.ps_sel = ps_eff;

  wdc_postscaler u_ps (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .ps(ps_link)
  );

  // ----------------------------------------------------------------
  // Run state
  // ----------------------------------------------------------------
  // The forced bit overrides the software enable in every state.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      WDC_LOAD: begin
        if (ld_done) begin
          nxt_state = (cfg_s2_ff[WDC_FORCE_BIT] || sw_en_ff) ? WDC_RUN : WDC_IDLE;
        end
      end
      WDC_IDLE: begin
        if (forced || sw_en_ff) begin
          nxt_state = WDC_RUN;
        end
      end
      WDC_RUN: begin
        if (!forced && !sw_en_ff) begin
          nxt_state = WDC_IDLE;
        end
      end
      default: nxt_state = WDC_LOAD;
    endcase
  end

  // Read data selection; unmapped and write-only offsets read as zero.
  always_comb begin
    case (addr_i)
      WDC_A_CTRL: nxt_rdata = {31'h0, sw_en_ff};
      WDC_A_STAT: nxt_rdata = {21'h0, ps_eff, wsz, wdis, forced, win_open, running};
      WDC_A_CFG: nxt_rdata = cfg_ff;
      WDC_A_CNT: nxt_rdata = {11'h0, ps_link.count};
      WDC_A_IST: nxt_rdata = {30'h0, ist_ff};
      WDC_A_IEN: nxt_rdata = {30'h0, ien_ff};
      default: nxt_rdata = 32'h0;
    endcase
  end

  // Configuration capture: two-stage synchroniser, then reloaded every cycle while in the load state.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_s1_ff <= WDC_CFG_RST;
      cfg_s2_ff <= WDC_CFG_RST;
      cfg_ff <= WDC_CFG_RST;
      ld_cnt_ff <= 2'h0;
    end else begin
      cfg_s1_ff <= cfg_word_i;
      cfg_s2_ff <= cfg_s1_ff;
      ld_cnt_ff <= ld_done ? ld_cnt_ff : ld_cnt_ff + 2'h1;
      cfg_ff <= (state_ff == WDC_LOAD) ? cfg_s2_ff : cfg_ff;
    end
  end

  // State, control and interrupt registers.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= WDC_LOAD;
      sw_en_ff <= WDC_SWEN_RST;
      ien_ff <= WDC_IEN_RST;
      ist_ff <= 2'h0;
    end else begin
      state_ff <= nxt_state;
      sw_en_ff <= wr_ctrl ? wdata_i[0] : sw_en_ff;
      ien_ff <= wr_ien ? wdata_i[1:0] : ien_ff;
      ist_ff <= nxt_ist;
    end
  end

  // Time base divider and registered outputs.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tb_cnt_ff <= 16'h0;
      rdata_o <= 32'h0;
      irq_o <= 1'b0;
      timeout_o <= 1'b0;
      running_o <= 1'b0;
    end else begin
      tb_cnt_ff <= (!running || ps_link.tick) ? 16'h0 : tb_cnt_ff + 16'h1;
      rdata_o <= rd_i ? nxt_rdata : 32'h0;
      irq_o <= |(nxt_ist & ien_ff);
      timeout_o <= tmo_ev;
      running_o <= (nxt_state == WDC_RUN);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  a_window_quarter: assert property (
    (ps_eff == 5'h3 && wsz == 2'h3) |-> (win_reached == (ps_link.count >= 21'h6)))
    else $error("Quarter window did not open at count six of eight.");
  a_window_three_q: assert property (
    (ps_eff == 5'h3 && wsz == 2'h0) |-> (win_reached == (ps_link.count >= 21'h2)))
    else $error("Three-quarter window did not open at count two of eight.");
  a_forced_runs: assert property (
    (state_ff != WDC_LOAD && forced) |-> (state_ff == WDC_RUN && running_o))
    else $error("Forced watchdog is not running.");
  a_off_at_load: assert property (
    (state_ff == WDC_LOAD && ld_done && !cfg_s2_ff[WDC_FORCE_BIT] && !sw_en_ff) |=> state_ff == WDC_IDLE)
    else $error("Unforced watchdog did not stay off after load.");
  a_sw_start: assert property (
    (state_ff == WDC_IDLE && sw_en_ff) |=> (state_ff == WDC_RUN && running_o))
    else $error("Software enable did not start the watchdog.");
  a_nowin_kick: assert property (
    (running && wdis && kick) |=> !timeout_o)
    else $error("Clear faulted in non-window operation.");
  a_ps_saturate: assert property (
    (ps_raw > 5'h14) |-> (ps_link.ps_sel == 5'h14))
    else $error("Undefined postscale code not treated as top code.");
  a_early_fault: assert property (
    (running && !wdis && kick && !win_reached) |=> (timeout_o && ist_ff[WDC_IRQ_EARLY] && ps_link.count == 21'h0))
    else $error("Early clear did not fault and restart.");
  a_inwin_kick: assert property (
    (running && kick && win_open) |=> (!timeout_o && ps_link.count == 21'h0))
    else $error("In-window clear did not restart quietly.");

  c_early: cover property (running && !wdis && early);
  c_expire: cover property (ps_link.expired ##1 irq_o);
  c_inwin: cover property (running && !wdis && kick && win_reached);
  c_sw_start: cover property (state_ff == WDC_IDLE && sw_en_ff);
  c_saturate: cover property (ps_raw > WDC_PS_MAX);

endmodule : wdc_top

// [tb/test_watchdog_config_decode.sv]
// Self-checking testbench for the watchdog built from the configuration word.
// Assumes wdc_top with its package and interface compiled first, one 100 MHz clock.
`timescale 1ns/1ps
module test_watchdog_config_decode;
  import wdc_pkg::*;

  localparam int TBC = 4;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [31:0] cfg_word_i = 32'hffff_ffff;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0000_0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic irq_o;
  logic timeout_o;
  logic running_o;
  int bad_count = 0;
  int checked = 0;
  int cycles = 0;
  logic [31:0] rv;
  logic seen;
  int n;

  // ----------------------------------------------------------------
  // Clock, hang guard and device
  // ----------------------------------------------------------------
  // The clock toggles every half period of 5 ns.
  always #5 mclk_i = ~mclk_i;

  // A run that outlives the planned length counts as a mismatch.
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 40000) begin
      bad_count++;
      print_verdict();
    end
  end

  wdc_top #(.TB_CYCLES(TBC)) dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .cfg_word_i(cfg_word_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .irq_o(irq_o), .timeout_o(timeout_o), .running_o(running_o));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  // Counts one comparison and reports a mismatch at once.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // Builds a word with the reserved bits written as ones.
  function automatic logic [31:0] cfg(input logic [1:0] wsz, input logic en, input logic wdis,
                                      input logic [4:0] ps);
    return {6'h3f, wsz, en, wdis, 1'b1, ps, 16'hffff};
  endfunction : cfg

  // Resets the block with a new word, since the word is captured once.
  task automatic do_reset(input logic [31:0] w);
    @(posedge mclk_i);
    rst_n_i <= 1'b0;
    cfg_word_i <= w;
    repeat (10) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    repeat (6) @(posedge mclk_i);
    #1;
  endtask : do_reset

  // One-cycle write strobe.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask : wr

  // One-cycle read strobe; data is taken in the following cycle.
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask : rd

  // Watches the timeout pulse for up to lim cycles and returns the cycles spent.
  task automatic watch(input int lim, output logic hit, output int cnt);
    cnt = 0;
    hit = 1'b0;
    while (!hit && cnt < lim) begin
      @(posedge mclk_i);
      #1;
      cnt++;
      hit = (timeout_o === 1'b1);
    end
  endtask : watch

  // Clears the watchdog; the timeout pulse of an early clear stands in the cycle right after the write.
  task automatic do_kick(output logic hit);
    logic h2;
    int c;
    wr(WDC_A_KICK, 32'h1);
    #1;
    hit = (timeout_o === 1'b1);
    watch(2, h2, c);
    hit = hit | h2;
  endtask : do_kick

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Measures the spacing of consecutive timeouts for several postscale codes.
  task automatic t_period();
    for (int p = 0; p < 4; p++) begin
      do_reset(cfg(2'h3, 1'b1, 1'b1, p[4:0]));
      watch(2000, seen, n);
      watch(2000, seen, n);
      check(32'(n), 32'((1 << p) * TBC));
    end
  endtask : t_period

  // Oversized postscale code, enable clear: idle until software starts it.
  task automatic t_saturate();
    do_reset(cfg(2'h3, 1'b0, 1'b1, 5'h1f));
    check({31'h0, running_o}, 32'h0);
    rd(WDC_A_STAT, rv);
    check({27'h0, rv[10:6]}, 32'h14);
    wr(WDC_A_CTRL, 32'h1);
    repeat (3) @(posedge mclk_i);
    #1;
    check({31'h0, running_o}, 32'h1);
  endtask : t_saturate

  // Forced enable, non-window kicks, interrupt and register map.
  task automatic t_forced();
    do_reset(cfg(2'h0, 1'b1, 1'b1, 5'h5));
    check({31'h0, running_o}, 32'h1);
    wr(WDC_A_CTRL, 32'h0);
    repeat (4) @(posedge mclk_i);
    #1;
    check({31'h0, running_o}, 32'h1);
    rd(WDC_A_STAT, rv);
    check({30'h0, rv[3:2]}, 32'h3);
    do_kick(seen);
    check({31'h0, seen}, 32'h0);
    wr(WDC_A_IEN, 32'h1);
    watch(2000, seen, n);
    repeat (2) @(posedge mclk_i);
    #1;
    check({31'h0, irq_o}, 32'h1);
    rd(WDC_A_IST, rv);
    check(rv, 32'h1);
    wr(WDC_A_IEN, 32'h0);
    repeat (2) @(posedge mclk_i);
    #1;
    check({31'h0, irq_o}, 32'h0);
    wr(WDC_A_IEN, 32'h1);
    wr(WDC_A_ICLR, 32'h1);
    repeat (2) @(posedge mclk_i);
    #1;
    check({31'h0, irq_o}, 32'h0);
    rd(WDC_A_IST, rv);
    check(rv, 32'h0);
    rd(8'h40, rv);
    check(rv, 32'h0);
    rd(WDC_A_KICK, rv);
    check(rv, 32'h0);
    wr(WDC_A_CFG, 32'h0);
    rd(WDC_A_CFG, rv);
    check(rv, cfg(2'h0, 1'b1, 1'b1, 5'h5));
    @(posedge mclk_i);
    #1;
    check(rdata_o, 32'h0);
  endtask : t_forced

  // Window mode for every size code: early clear faults, in-window clear restarts.
  task automatic t_window();
    logic [31:0] k;
    for (int w = 0; w < 4; w++) begin
      k = (w == 3) ? 32'h6 : (w == 2) ? 32'h5 : (w == 1) ? 32'h4 : 32'h2;
      do_reset(cfg(w[1:0], 1'b1, 1'b0, 5'h3));
      rd(WDC_A_STAT, rv);
      check({29'h0, rv[5:3]}, {29'h0, w[1:0], 1'b0});
      do_kick(seen);
      check({31'h0, seen}, 32'h1);
      rd(WDC_A_STAT, rv);
      check({31'h0, rv[1]}, 32'h0);
      rd(WDC_A_IST, rv);
      check({31'h0, rv[1]}, 32'h1);
      wr(WDC_A_ICLR, 32'h2);
      n = 0;
      do begin
        rd(WDC_A_CNT, rv);
        n++;
      end while (rv < k && n < 100);
      rd(WDC_A_STAT, rv);
      check({31'h0, rv[1]}, 32'h1);
      do_kick(seen);
      check({31'h0, seen}, 32'h0);
      rd(WDC_A_CNT, rv);
      check({31'h0, rv < k}, 32'h1);
      rd(WDC_A_IST, rv);
      check(rv, 32'h0);
    end
  endtask : t_window

  // ----------------------------------------------------------------
  // Verdict and main sequence
  // ----------------------------------------------------------------
  // Prints the verdict and ends the run.
  task automatic print_verdict();
    if (bad_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict

  // Runs every scenario in turn.
  initial begin
    t_period();
    t_saturate();
    t_forced();
    t_window();
    print_verdict();
  end
endmodule : test_watchdog_config_decode
